/* File: core/epc_map.svh */
// Purpose: constants for the programmer-side memory controller
// Assumes: 100 MHz clock, 10 ns period
// Notes:   times in ns, cycle counts derived from them
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH
`define EPC_CLK_PERIOD_NS   10
`define EPC_PULSE_NS        100000
`define EPC_PULSE_CYC       (`EPC_PULSE_NS / `EPC_CLK_PERIOD_NS)
`define EPC_PW_MIN_CYC      (`EPC_PULSE_CYC * 95 / 100)
`define EPC_PW_MAX_CYC      (`EPC_PULSE_CYC * 105 / 100)
`define EPC_SETUP_NS        2000
`define EPC_SETUP_CYC       ((`EPC_SETUP_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_ACCESS_NS       200
`define EPC_ACCESS_CYC      ((`EPC_ACCESS_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_MAX_PULSES      10
`define EPC_ERASED_BYTE     8'hFF
`endif

/* File: core/epc_pkg.sv */
// Purpose: types for the programmer-side memory controller
// Assumes: nothing
// Notes:   commands and pin bundle
`default_nettype none
package epc_pkg;
  // host commands
  typedef enum logic [1:0] {EPC_CMD_READ, EPC_CMD_PROG, EPC_CMD_IDENT} epc_cmd_t;
  // pin bundle driven toward the memory
  typedef struct packed {
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        vpp_high;
    logic        id_high;
    logic [14:0] address_lines;
  } epc_pins_t;
endpackage : epc_pkg
`default_nettype wire

/* File: core/epc_timer.sv */
// Purpose: loadable down-counter for pin timing
// Assumes: one clock, synchronous reset
// Notes:   done is a level while the count is zero
`default_nettype none
module epc_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        load_i,
  input  wire logic [15:0] count_i,
  output logic             done_o
);
  logic [15:0] cnt_ff; // remaining cycles
  // count down to zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 16'h0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_ff <= count_i;
      end else if (cnt_ff != 16'h0) begin
        cnt_ff <= cnt_ff - 16'h1;
      end
    end
  end
  assign done_o = (cnt_ff == 16'h0);
endmodule : epc_timer
`default_nettype wire

/* File: core/epc_ctrl.sv */
// Purpose: host/programmer controller for a 32K x 8 one-time memory
// Assumes: data lines are two-way, resolved outside; all pins levels
// Notes:   read, identity read and fast byte programming with verify
// Overview of operation
// - program: high supply, gate high, select pulse
// - at most ten 100 us pulses per byte
// - no extra pulses after byte verifies
// - 15-bit address, 8-bit shared data lines
// - program pulse lasts 100 us
`include "epc_map.svh"
`default_nettype none
module epc_ctrl (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              CE_I,
  input  wire logic              REQ_I,
  input  wire epc_pkg::epc_cmd_t CMD_I,
  input  wire logic [14:0]       ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic [7:0]        DATA_LINES_I,
  output logic                   BUSY_O,
  output logic                   DONE_O,
  output logic                   FAIL_O,
  output logic [7:0]             RDATA_O,
  output logic [3:0]             PULSES_O,
  output epc_pkg::epc_pins_t     PINS_O,
  output logic [7:0]             DATA_LINES_O,
  output logic                   DATA_LINES_OE_O
);
  import epc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RSETUP, S_RWAIT, S_PSETUP, S_PULSE,
                            S_VSETUP, S_VWAIT, S_END} epc_state_t;

  epc_state_t   state_ff;       // sequencer state
  epc_cmd_t     cmd_ff;         // latched command
  logic [7:0]   wdata_ff;       // byte being programmed
  logic [7:0]   d_meta_ff;      // synchroniser stage 1
  logic [7:0]   d_sync_ff;      // synchroniser stage 2
  logic         t_load;         // timer reload
  logic [15:0]  t_count;        // timer value
  logic         t_done;         // timer expired

  // cycle counts sized to the timer
  localparam logic [15:0] PULSE_CYC  = 16'(`EPC_PULSE_CYC);
  localparam logic [15:0] SETUP_CYC  = 16'(`EPC_SETUP_CYC);
  localparam logic [15:0] ACCESS_CYC = 16'(`EPC_ACCESS_CYC + 2);
  localparam logic [3:0]  MAX_PULSES = 4'(`EPC_MAX_PULSES);

  // set when the verified byte differs from the byte being programmed
  function automatic logic mismatch(input logic [7:0] want, input logic [7:0] got);
    mismatch = (want != got);
  endfunction : mismatch

  epc_timer u_timer (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .load_i  (t_load),
    .count_i (t_count),
    .done_o  (t_done)
  );

  // two-flop sync of the data pins
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      d_meta_ff <= 8'h00;
      d_sync_ff <= 8'h00;
    end else if (CE_I) begin
      d_meta_ff <= DATA_LINES_I;
      d_sync_ff <= d_meta_ff;
    end
  end

  // timer reload on leaving each state except S_RWAIT and S_END
  always_comb begin
    t_load  = 1'b0;
    t_count = 16'h0;
    if (CE_I) begin
      unique case (state_ff)
        S_IDLE: begin
          t_load  = REQ_I;
          t_count = SETUP_CYC;
        end
        S_RSETUP: begin
          t_load  = t_done;
          t_count = ACCESS_CYC;
        end
        S_PSETUP: begin
          t_load  = t_done;
          t_count = PULSE_CYC;
        end
        S_PULSE: begin
          t_load  = t_done;
          t_count = SETUP_CYC;
        end
        S_VSETUP: begin
          t_load  = t_done;
          t_count = ACCESS_CYC;
        end
        S_VWAIT: begin
          t_load  = t_done;
          t_count = SETUP_CYC;
        end
        S_RWAIT, S_END: begin
          t_load  = 1'b0;
          t_count = 16'h0;
        end
      endcase
    end
  end

  // sequencer and pulse count
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_ff <= S_IDLE;
      cmd_ff   <= EPC_CMD_READ;
      wdata_ff <= `EPC_ERASED_BYTE;
      PULSES_O <= 4'h0;
      FAIL_O   <= 1'b0;
      DONE_O   <= 1'b0;
      RDATA_O  <= 8'h00;
    end else if (CE_I) begin
      DONE_O <= 1'b0;
      unique case (state_ff)
        S_IDLE: begin
          if (REQ_I) begin
            cmd_ff   <= CMD_I;
            wdata_ff <= WDATA_I;
            PULSES_O <= 4'h0;
            FAIL_O   <= 1'b0;
            state_ff <= (CMD_I == EPC_CMD_PROG) ? S_PSETUP : S_RSETUP;
          end
        end
        S_RSETUP: if (t_done) state_ff <= S_RWAIT;
        S_RWAIT: begin
          if (t_done) begin
            RDATA_O  <= d_sync_ff;
            state_ff <= S_END;
          end
        end
        S_PSETUP: begin
          if (t_done) begin
            PULSES_O <= PULSES_O + 4'h1;
            state_ff <= S_PULSE;
          end
        end
        S_PULSE: if (t_done) state_ff <= S_VSETUP;
        S_VSETUP: if (t_done) state_ff <= S_VWAIT;
        S_VWAIT: begin
          if (t_done) begin
            RDATA_O <= d_sync_ff;
            if (!mismatch(wdata_ff, d_sync_ff)) begin
              state_ff <= S_END;
            end else if (PULSES_O >= MAX_PULSES) begin
              FAIL_O   <= 1'b1;
              state_ff <= S_END;
            end else begin
              state_ff <= S_PSETUP;
            end
          end
        end
        S_END: begin
          DONE_O   <= 1'b1;
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // pin levels per state, all registered
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PINS_O          <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, vpp_high: 1'b0,
                           id_high: 1'b0, address_lines: 15'h0000};
      DATA_LINES_O    <= 8'hFF;
      DATA_LINES_OE_O <= 1'b0;
      BUSY_O          <= 1'b0;
    end else if (CE_I) begin
      BUSY_O <= (state_ff != S_IDLE) || REQ_I;
      if (state_ff == S_IDLE && REQ_I) begin
        PINS_O.address_lines <= ADDR_I;
        PINS_O.id_high       <= (CMD_I == EPC_CMD_IDENT);
        PINS_O.vpp_high      <= (CMD_I == EPC_CMD_PROG);
        DATA_LINES_O         <= WDATA_I;
        DATA_LINES_OE_O      <= (CMD_I == EPC_CMD_PROG);
      end
      unique case (state_ff)
        S_IDLE, S_END: begin
          PINS_O.chip_sel_n <= 1'b1;
          PINS_O.out_gate_n <= 1'b1;
          if (state_ff == S_END) begin
            PINS_O.vpp_high <= 1'b0;
            PINS_O.id_high  <= 1'b0;
            DATA_LINES_OE_O <= 1'b0;
          end
        end
        S_RSETUP: begin
          if (t_done) begin
            PINS_O.chip_sel_n <= 1'b0;
            PINS_O.out_gate_n <= 1'b0;
          end
        end
        S_RWAIT: ;
        S_PSETUP: begin
          DATA_LINES_OE_O   <= 1'b1;
          PINS_O.out_gate_n <= 1'b1;
          if (t_done) PINS_O.chip_sel_n <= 1'b0;
        end
        S_PULSE: begin
          if (t_done) PINS_O.chip_sel_n <= 1'b1;
        end
        S_VSETUP: begin
          DATA_LINES_OE_O <= 1'b0;
          if (t_done) PINS_O.out_gate_n <= 1'b0;
        end
        S_VWAIT: begin
          if (t_done) PINS_O.out_gate_n <= 1'b1;
        end
      endcase
    end
  end

  // helper: cycles of the current select pulse at high supply
  logic [15:0] pw_cnt_ff; // pulse length so far
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pw_cnt_ff <= 16'h0;
    end else if (CE_I) begin
      pw_cnt_ff <= (PINS_O.vpp_high && !PINS_O.chip_sel_n) ? pw_cnt_ff + 16'h1 : 16'h0;
    end
  end
  // checks
  sequence s_pulse_start;
    $fell(PINS_O.chip_sel_n) && PINS_O.vpp_high;
  endsequence
  property p_pulse_width;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      s_pulse_start |-> PINS_O.chip_sel_n == 1'b0 [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse too short");
  property p_pulse_len;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      ($rose(PINS_O.chip_sel_n) && PINS_O.vpp_high) |->
        (pw_cnt_ff >= 16'(`EPC_PW_MIN_CYC) && pw_cnt_ff <= 16'(`EPC_PW_MAX_CYC));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length out of band");
  property p_gate_in_prog;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (PINS_O.vpp_high && !PINS_O.chip_sel_n) |-> PINS_O.out_gate_n;
  endproperty
  a_gate_in_prog: assert property (p_gate_in_prog) else $error("gate low in pulse");
  property p_max_pulses;
    @(posedge CLK_I) disable iff (!RST_N_I) PULSES_O <= MAX_PULSES;
  endproperty
  a_max_pulses: assert property (p_max_pulses) else $error("too many pulses");
  property p_no_contend;
    @(posedge CLK_I) disable iff (!RST_N_I)
      !PINS_O.out_gate_n |-> !DATA_LINES_OE_O;
  endproperty
  a_no_contend: assert property (p_no_contend) else $error("bus contention");
  property p_vpp_low_read;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (state_ff == S_RWAIT) |-> !PINS_O.vpp_high;
  endproperty
  a_vpp_low_read: assert property (p_vpp_low_read) else $error("supply high in read");
  property p_fail_at_ten;
    @(posedge CLK_I) disable iff (!RST_N_I)
      $rose(FAIL_O) |-> PULSES_O == MAX_PULSES;
  endproperty
  a_fail_at_ten: assert property (p_fail_at_ten) else $error("fail before tenth");
  property p_verify_levels;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (state_ff == S_VWAIT) |-> (PINS_O.chip_sel_n && PINS_O.vpp_high);
  endproperty
  a_verify_levels: assert property (p_verify_levels) else $error("bad verify levels");
  property p_done_pulse;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      DONE_O |-> (!PINS_O.vpp_high && PINS_O.chip_sel_n) ##1 !DONE_O;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
endmodule : epc_ctrl
`default_nettype wire

/* File: tb/epc_mem_model.sv */
// Purpose: behavioural one-time memory facing the controller pins
// Assumes: data lines resolved by the bench from the controller enable
// Notes:   a byte takes its zeros only after NEED_PULSES pulses in one run
`default_nettype none
module epc_mem_model
  import epc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h5A, // arbitrary value
  parameter logic [7:0] TYPE_CODE   = 8'hC3, // arbitrary value
  parameter int         NEED_PULSES = 2,
  parameter int         ACCESS_NS   = 200 // select or gate to valid data, ns
) (
  input  wire epc_pkg::epc_pins_t pins_i,
  input  wire logic [7:0]         data_i,
  input  wire logic               host_oe_i,
  output logic [7:0]              data_o,
  output logic                    oe_o,
  output int                      n_viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:32767]; // cell array
  logic [7:0] last;          // last byte driven
  logic [7:0] d_lat;         // byte held at pulse start
  logic       rd_en;         // read or identity mode
  logic       vf_en;         // verify mode
  wire logic  oe_late;       // enable held for the whole access delay
  int         run;           // pulses in this supply-high run
  realtime    t_fall;        // start of select pulse
  // erased array
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    n_viol_o = 0;
    last = 8'h00;
    run = 0;
  end
  assign rd_en = !pins_i.vpp_high && !pins_i.chip_sel_n && !pins_i.out_gate_n;
  assign vf_en = pins_i.vpp_high && pins_i.chip_sel_n && !pins_i.out_gate_n;
  assign oe_o  = rd_en || vf_en;
  assign #(ACCESS_NS) oe_late = oe_o;
  // output mux; until the access delay is over, and when released, the inverse of the last byte
  always_comb begin
    data_o = ~last;
    if (oe_o && oe_late) begin
      if (rd_en && pins_i.id_high) begin
        data_o = pins_i.address_lines[0] ? TYPE_CODE : MAKER_CODE;
      end else begin
        data_o = mem[pins_i.address_lines];
      end
    end
  end
  // remember what was driven once valid
  always @(oe_o or oe_late or data_o) if (oe_o && oe_late) last = data_o;
  // pulse start: program conditions must hold
  always @(negedge pins_i.chip_sel_n) begin
    t_fall = $realtime;
    d_lat = data_i;
    if (pins_i.vpp_high && (!pins_i.out_gate_n || !host_oe_i)) n_viol_o++;
  end
  // supply dropped: new run of pulses
  always @(negedge pins_i.vpp_high) run = 0;
  // pulse end: only a selected byte is written, zeros only
  always @(posedge pins_i.chip_sel_n) begin
    if (pins_i.vpp_high === 1'b1 && pins_i.out_gate_n === 1'b1) begin
      if ($realtime - t_fall < 95000.0 || $realtime - t_fall > 105000.0) n_viol_o++;
      run = run + 1;
      if (run > 10) n_viol_o++;
      if (run >= NEED_PULSES) mem[pins_i.address_lines] &= d_lat;
    end
  end
endmodule : epc_mem_model
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the memory controller
// Assumes: full-length pulses, so a failing byte takes about 104k cycles
// Notes:   inputs change on the falling clock edge
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import epc_pkg::*;
  logic       clk, rst_n, req, ce;    // clock, reset, request, clock enable
  epc_cmd_t   cmd;                    // command
  logic [14:0] addr;                  // address
  logic [7:0] wdata, bus, rdata;      // write byte, wire level, read byte
  logic [7:0] c_dout, m_dout;         // drive values
  logic       c_oe, m_oe, busy, done, fail;
  logic [3:0] pulses;                 // pulses used
  epc_pins_t  pins;                   // pins to memory
  int         n_viol, n_errors, n_checks;
  assign bus = c_oe ? c_dout : m_dout;
  epc_ctrl uut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REQ_I(req), .CMD_I(cmd),
    .ADDR_I(addr), .WDATA_I(wdata), .DATA_LINES_I(bus), .BUSY_O(busy), .DONE_O(done),
    .FAIL_O(fail), .RDATA_O(rdata), .PULSES_O(pulses), .PINS_O(pins),
    .DATA_LINES_O(c_dout), .DATA_LINES_OE_O(c_oe));
  epc_mem_model mem (.pins_i(pins), .data_i(bus), .host_oe_i(c_oe), .data_o(m_dout),
    .oe_o(m_oe), .n_viol_o(n_viol));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // one comparison
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one command; poke sends a request while busy, which must be ignored
  task automatic run(input epc_cmd_t c, input logic [14:0] a, input logic [7:0] d,
                     input bit poke);
    int n;
    @(negedge clk);
    req = 1'b1; cmd = c; addr = a; wdata = d;
    @(negedge clk);
    req = 1'b0;
    chk("busy", 8'h01, {7'h0, busy});
    if (poke) begin
      repeat (50) @(negedge clk);
      req = 1'b1; cmd = EPC_CMD_IDENT;
      @(negedge clk);
      req = 1'b0;
      chk("poke ignored", 8'h02, {6'h0, pins.vpp_high, pins.id_high});
    end
    n = 0;
    while (done !== 1'b1 && n < 120000) begin
      @(negedge clk);
      n++;
    end
    chk("done", 8'h01, {7'h0, done});
  endtask : run
  // clock enable low: a request is not taken and the pins stand still
  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0; req = 1'b1; cmd = EPC_CMD_PROG; addr = 15'h0001;
    repeat (3) @(negedge clk);
    req = 1'b0;
    chk("frozen busy", 8'h00, {7'h0, busy});
    chk("frozen pins", 8'h0C, {4'h0, pins.chip_sel_n, pins.out_gate_n, pins.vpp_high,
        pins.id_high});
    ce = 1'b1;
  endtask : t_freeze
  // erased read and identity codes
  task automatic t_reads();
    run(EPC_CMD_READ, 15'h7FFF, 8'h00, 0);
    chk("erased", 8'hFF, rdata);
    run(EPC_CMD_IDENT, 15'h0000, 8'h00, 0);
    chk("maker", 8'h5A, rdata);
    run(EPC_CMD_IDENT, 15'h0001, 8'h00, 0);
    chk("type", 8'hC3, rdata);
  endtask : t_reads
  // good byte after two pulses, refused request in the middle
  task automatic t_prog();
    run(EPC_CMD_PROG, 15'h1234, 8'hA5, 1);
    chk("fail", 8'h00, {7'h0, fail});
    chk("pulses", 8'h02, {4'h0, pulses});
    @(negedge clk);
    chk("idle", 8'h0C, {4'h0, pins.chip_sel_n, pins.out_gate_n, pins.vpp_high,
        pins.id_high});
    run(EPC_CMD_READ, 15'h1234, 8'h00, 0);
    chk("readback", 8'hA5, rdata);
  endtask : t_prog
  // byte needing ones never verifies: ten pulses then failure
  task automatic t_fail();
    run(EPC_CMD_PROG, 15'h1234, 8'h5A, 0);
    chk("fail", 8'h01, {7'h0, fail});
    chk("pulses", 8'h0A, {4'h0, pulses});
    run(EPC_CMD_READ, 15'h1234, 8'h00, 0);
    chk("zeros only", 8'h00, rdata);
  endtask : t_fail
  // both sides never drive the data lines together
  always @(negedge clk) begin
    if (c_oe === 1'b1 && m_oe === 1'b1) begin
      n_errors++;
      $display("Error contention expected 0 seen 1");
    end
  end
  // watchdog
  initial begin
    #3000000;
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    summarize();
  end
  // main sequence
  initial begin
    n_errors = 0; n_checks = 0;
    rst_n = 1'b0; req = 1'b0; cmd = EPC_CMD_READ; addr = 15'h0000; wdata = 8'h00;
    ce = 1'b1;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("reset pins", 8'h0C, {4'h0, pins.chip_sel_n, pins.out_gate_n, pins.vpp_high,
        pins.id_high});
    chk("reset oe", 8'h00, {7'h0, c_oe});
    t_freeze();
    t_reads();
    t_prog();
    t_fail();
    chk("pin faults", 8'h00, n_viol[7:0]);
    summarize();
  end
endmodule : tb
`default_nettype wire
